// ---- bench/tb_gm_align.sv ----
// self-checking bench for master selection and pulse-steered timebase
`timescale 1ns/1ps
module tb_gm_align;
	localparam int LIMIT = 30000;
	logic clk, srst, gm_mode, cand_valid, cand_clear, amt_en, amt_wr, amt_ev;
	logic [2:0] ref_sel, amt_idx, src_bit;
	logic [7:0] ref_in, ser_byte, amt_prio, day_r, t_day;
	logic [15:0] amt_id;
	logic ser_valid, ser_err, best_valid_r, best_gm_capable_r, cand_reject_r;
	logic top_sec_r, pps_lost_r, ser_fail_r, seen, r;
	logic [23:0] sub_r, t_sub;
	logic [16:0] sec_r, t_sec;
	gm_align_pkg::cfg_t cfg;
	gm_align_pkg::cand_t cand, best_r;
	gm_align_pkg::ann_t ann_r, ea, ga;
	gm_align_pkg::sync_state_t state_r;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	// short windows keep the run brief
	gm_align #(.PPS_WIN(32'd400), .SER_WIN(32'd2000)) gm_align_inst (
		.clk(clk), .srst(srst), .gm_mode(gm_mode), .ref_sel(ref_sel),
		.reference_clock_input(ref_in), .ser_byte(ser_byte), .ser_valid(ser_valid),
		.ser_err(ser_err), .cfg(cfg), .cand(cand), .cand_valid(cand_valid),
		.cand_clear(cand_clear), .amt_en(amt_en), .amt_wr(amt_wr), .amt_idx(amt_idx),
		.amt_id(amt_id), .amt_prio(amt_prio), .amt_entry_valid(amt_ev), .best_r(best_r),
		.best_valid_r(best_valid_r), .best_gm_capable_r(best_gm_capable_r),
		.cand_reject_r(cand_reject_r), .ann_r(ann_r), .sub_r(sub_r), .sec_r(sec_r),
		.day_r(day_r), .top_sec_r(top_sec_r), .state_r(state_r),
		.pps_lost_r(pps_lost_r), .ser_fail_r(ser_fail_r));
	time_source time_source_inst (.clk(clk), .pps_bit(src_bit), .ref_in(ref_in),
		.ser_byte(ser_byte), .ser_valid(ser_valid), .ser_err(ser_err));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic end_sim();
		if (err_total == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_total++;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %0h got %0h", n, e, g);
		end
	endtask : chk
	task automatic put(input logic [15:0] id, input logic [7:0] p1, cl, ac,
		input logic [15:0] va, input logic [7:0] p2);
		@(negedge clk);
		cand = '{id, p1, cl, ac, va, p2};
		cand_valid = 1'b1;
		@(negedge clk);
		cand_valid = 1'b0;
		r = cand_reject_r;
	endtask : put
	task automatic clr();
		@(negedge clk);
		cand_clear = 1'b1;
		@(negedge clk);
		cand_clear = 1'b0;
	endtask : clr
	task automatic aw(input logic [2:0] ix, input logic [15:0] id, input logic [7:0] p,
		input logic v);
		@(negedge clk);
		amt_wr = 1'b1;
		amt_idx = ix;
		amt_id = id;
		amt_prio = p;
		amt_ev = v;
		@(negedge clk);
		amt_wr = 1'b0;
	endtask : aw
	// one pulse; records the rollover cycle's time values
	task automatic pulse_once();
		seen = 1'b0;
		time_source_inst.pps_rise();
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			#1;
			if (top_sec_r === 1'b1 && seen === 1'b0) begin
				seen = 1'b1;
				t_sub = sub_r;
				t_sec = sec_r;
				t_day = day_r;
			end
		end
		repeat (3) @(negedge clk);
		time_source_inst.pps_fall();
		repeat (20) @(negedge clk);
	endtask : pulse_once
	task automatic t_bmca();
		clr();
		chk("bvalid", 0, best_valid_r);
		put(16'h0001, 8'h0a, 8'hc8, 8'hfe, 16'hffff, 8'h09);
		put(16'h0002, 8'h14, 8'h06, 8'h20, 16'h0100, 8'h01);
		chk("id", 16'h0001, best_r.id);
		chk("gmcap", 0, best_gm_capable_r);
		// lower first priority displaces a held best despite worse quality
		put(16'h000a, 8'h05, 8'hff, 8'hff, 16'hffff, 8'hff);
		chk("id", 16'h000a, best_r.id);
		clr();
		put(16'h0003, 8'h32, 8'h07, 8'h20, 16'h0100, 8'h01);
		put(16'h0004, 8'h32, 8'h06, 8'h30, 16'h0100, 8'h01);
		chk("id", 16'h0004, best_r.id);
		put(16'h0005, 8'h32, 8'h06, 8'h21, 16'h0200, 8'h01);
		chk("id", 16'h0005, best_r.id);
		put(16'h0006, 8'h32, 8'h06, 8'h21, 16'h0100, 8'h01);
		chk("id", 16'h0006, best_r.id);
		put(16'h0007, 8'h32, 8'h06, 8'h21, 16'h0100, 8'h00);
		chk("id", 16'h0007, best_r.id);
		clr();
		put(16'h0008, 8'h32, 8'h80, 8'h00, 16'h0000, 8'h00);
		chk("gmcap", 0, best_gm_capable_r);
		put(16'h0009, 8'h32, 8'h7f, 8'hfe, 16'hffff, 8'hff);
		chk("id", 16'h0009, best_r.id);
		chk("gmcap", 1, best_gm_capable_r);
	endtask : t_bmca
	task automatic t_amt();
		@(negedge clk);
		amt_en = 1'b1;
		aw(3'h0, 16'h0100, 8'h05, 1'b1);
		aw(3'h7, 16'h0200, 8'h09, 1'b1);
		clr();
		put(16'h0300, 8'h00, 8'h06, 8'h20, 16'h0100, 8'h00);
		chk("rej", 1, r);
		chk("bvalid", 0, best_valid_r);
		put(16'h0200, 8'h01, 8'h06, 8'h20, 16'h0100, 8'h00);
		chk("prio", 8'h09, best_r.prio1);
		put(16'h0100, 8'hfa, 8'h06, 8'h20, 16'h0100, 8'h00);
		chk("id", 16'h0100, best_r.id);
		chk("prio", 8'h05, best_r.prio1);
		aw(3'h0, 16'h0100, 8'h05, 1'b0);
		put(16'h0100, 8'h00, 8'h06, 8'h20, 16'h0100, 8'h00);
		chk("rej", 1, r);
		@(negedge clk);
		amt_en = 1'b0;
	endtask : t_amt
	task automatic ann(input logic tr, input logic pa, input logic [7:0] ecl);
		@(negedge clk);
		cfg.traceable = tr;
		cfg.profile_active = pa;
		repeat (2) @(negedge clk);
		ea = '{tr, tr, 1'b1, tr, 1'b0, tr, tr ? 16'h0025 : 16'h0000, 8'h20, ecl, 8'h21,
			16'h4e5d};
		ga = ann_r;
		// offset value is meaningless once marked invalid
		if (!tr) ga.utc_offset = 16'h0000;
		chk("announce", ea, ga);
	endtask : ann
	task automatic t_tod();
		pulse_once();
		chk("seen", 0, seen);
		@(negedge clk);
		gm_mode = 1'b1;
		time_source_inst.send_line("$GPZDA,000001.00,01,01,2024,00,00*");
		chk("serfail", 0, ser_fail_r);
		pulse_once();
		chk("seen", 1, seen);
		chk("sec", 0, t_sec);
		chk("ppslost", 0, pps_lost_r);
		time_source_inst.send_line("$GPZDA,123456.00,15,03,2024,00,00*");
		pulse_once();
		chk("sub", 0, t_sub);
		chk("sec", 17'h0_b0f0, t_sec);
		chk("day", 8'h0f, t_day);
		time_source_inst.send_line("$GPGGA,010203.00,4807.038,N*");
		pulse_once();
		chk("sec", 17'h0_b0f0, t_sec);
		time_source_inst.line_fault();
		chk("serfail", 1, ser_fail_r);
		time_source_inst.send_line("$GPZDA,010000.00,02,03,2024,00,00*");
		// a good sentence clears the failure but its time is not used
		chk("serfail", 0, ser_fail_r);
		pulse_once();
		chk("seen", 1, seen);
		chk("sec", 17'h0_b0f0, t_sec);
	endtask : t_tod
	task automatic t_lock();
		for (int i = 0; i < 20 && state_r !== gm_align_pkg::ST_LOCKED; i++) pulse_once();
		chk("state", gm_align_pkg::ST_LOCKED, state_r);
		repeat (350) @(negedge clk);
		chk("ppslost", 0, pps_lost_r);
		for (int i = 0; i < 100 && pps_lost_r !== 1'b1; i++) @(negedge clk);
		chk("ppslost", 1, pps_lost_r);
		// state follows the lost flag one cycle later
		@(negedge clk);
		chk("state", gm_align_pkg::ST_HOLD, state_r);
		@(negedge clk);
		src_bit = 3'h5;
		pulse_once();
		chk("seen", 0, seen);
		chk("ppslost", 1, pps_lost_r);
		@(negedge clk);
		ref_sel = 3'h5;
		pulse_once();
		chk("seen", 1, seen);
		chk("state", gm_align_pkg::ST_LOCKING, state_r);
		repeat (450) @(negedge clk);
		chk("state", gm_align_pkg::ST_FREE, state_r);
		// silence past the serial window marks the input failed
		repeat (1000) @(negedge clk);
		chk("serfail", 1, ser_fail_r);
	endtask : t_lock
	initial begin
		srst = 1'b1;
		gm_mode = 1'b0;
		ref_sel = 3'h3;
		src_bit = 3'h3;
		cfg = '{1'b0, 1'b0, 8'h34, 8'h21, 16'h4e5d, 16'h0025, 8'h20, 1'b1, 1'b0};
		cand = '0;
		cand_valid = 1'b0;
		cand_clear = 1'b0;
		amt_en = 1'b0;
		amt_wr = 1'b0;
		amt_idx = 3'h0;
		amt_id = 16'h0000;
		amt_prio = 8'h00;
		amt_ev = 1'b0;
		repeat (20) @(negedge clk);
		srst = 1'b0;
		chk("ppslost", 1, pps_lost_r);
		chk("state", gm_align_pkg::ST_FREE, state_r);
		t_bmca();
		t_amt();
		ann(1'b1, 1'b0, 8'h06);
		ann(1'b1, 1'b1, 8'h34);
		ann(1'b0, 1'b0, 8'h0d);
		ann(1'b0, 1'b1, 8'h34);
		t_tod();
		t_lock();
		end_sim();
	end
endmodule : tb_gm_align

// ---- bench/time_source.sv ----
// far-side time source model: serial time sentences and pulse line
`timescale 1ns/1ps
module time_source (
	input wire logic clk,
	input wire logic [2:0] pps_bit,
	output logic [7:0] ref_in,
	output logic [7:0] ser_byte,
	output logic ser_valid,
	output logic ser_err
);
	initial begin
		ref_in = 8'h00;
		ser_byte = 8'h00;
		ser_valid = 1'b0;
		ser_err = 1'b0;
	end
	// whole sentence delivered before the pulse it names
	task automatic send_line(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(negedge clk);
			ser_byte = s[i];
			ser_valid = 1'b1;
			@(negedge clk);
			ser_valid = 1'b0;
			// idle line must not keep the last character
			ser_byte = ~ser_byte;
		end
	endtask : send_line
	// rising edge marks top of second
	task automatic pps_rise();
		@(negedge clk);
		ref_in[pps_bit] = 1'b1;
	endtask : pps_rise
	task automatic pps_fall();
		@(negedge clk);
		ref_in[pps_bit] = 1'b0;
	endtask : pps_fall
	// framing error arrives with its strobe
	task automatic line_fault();
		@(negedge clk);
		ser_err = 1'b1;
		ser_valid = 1'b1;
		@(negedge clk);
		ser_err = 1'b0;
		ser_valid = 1'b0;
	endtask : line_fault
endmodule : time_source

// ---- logic/gm_align.sv ----
// master selection, time message intake and pulse-steered timebase
`timescale 1ns/1ps
`include "gm_align_cfg.svh"
module gm_align #(
	parameter logic [31:0] PPS_WIN = 32'(`PPS_WIN_CYC),
	parameter logic [31:0] SER_WIN = 32'(`SER_WIN_CYC)
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic gm_mode,
	input wire logic [2:0] ref_sel,
	input wire logic [7:0] reference_clock_input,
	input wire logic [7:0] ser_byte,
	input wire logic ser_valid,
	input wire logic ser_err,
	input wire gm_align_pkg::cfg_t cfg,
	input wire gm_align_pkg::cand_t cand,
	input wire logic cand_valid,
	input wire logic cand_clear,
	input wire logic amt_en,
	input wire logic amt_wr,
	input wire logic [2:0] amt_idx,
	input wire logic [15:0] amt_id,
	input wire logic [7:0] amt_prio,
	input wire logic amt_entry_valid,
	output gm_align_pkg::cand_t best_r,
	output logic best_valid_r,
	output logic best_gm_capable_r,
	output logic cand_reject_r,
	output gm_align_pkg::ann_t ann_r,
	output logic [23:0] sub_r,
	output logic [16:0] sec_r,
	output logic [7:0] day_r,
	output logic top_sec_r,
	output gm_align_pkg::sync_state_t state_r,
	output logic pps_lost_r,
	output logic ser_fail_r
);
	// allowed_master_list storage
	logic [15:0] amt_id_r [`AMT_DEPTH];
	logic [7:0] amt_prio_r [`AMT_DEPTH];
	logic [`AMT_DEPTH-1:0] amt_v_r;
	logic [`AMT_DEPTH-1:0] hit;
	logic [7:0] hit_prio [`AMT_DEPTH];
	logic amt_hit;
	logic [7:0] eff_p1;
	logic cand_ok;
	gm_align_pkg::cand_t eff;
	logic pps_d_r;
	logic pps_now;
	logic pps_edge;
	logic [31:0] pps_cnt_r;
	logic [31:0] ser_cnt_r;
	logic [7:0] lock_secs_r;
	logic [7:0] idx_r;
	logic [3:0] fld_r;
	logic [3:0] pos_r;
	logic zda_r;
	logic [7:0] hh_r;
	logic [7:0] mm_r;
	logic [7:0] ss_r;
	logic [7:0] dd_r;
	logic pend_v_r;
	logic [16:0] pend_sec_r;
	logic [7:0] pend_day_r;
	logic is_dig;
	logic [7:0] dig;
	logic msg_end;
	logic msg_good;

	always_ff @(posedge clk) begin
		if (srst) begin
			amt_v_r <= '0;
		end else if (amt_wr) begin
			amt_v_r[amt_idx] <= amt_entry_valid;
			amt_id_r[amt_idx] <= amt_id;
			amt_prio_r[amt_idx] <= amt_prio;
		end
	end

	// per-entry match; ids are assumed unique so priorities can be or-ed
	for (genvar i = 0; i < `AMT_DEPTH; i++) begin : g_amt
		assign hit[i] = amt_v_r[i] && (amt_id_r[i] == cand.id);
		assign hit_prio[i] = hit[i] ? amt_prio_r[i] : 8'h00;
	end

	always_comb begin
		eff_p1 = 8'h00;
		for (int i = 0; i < `AMT_DEPTH; i++) begin
			eff_p1 = eff_p1 | hit_prio[i];
		end
	end

	assign amt_hit = |hit;
	always_comb begin
		eff = cand;
		if (amt_en && amt_hit) begin
			eff.prio1 = eff_p1;
		end
	end

	// unlisted candidates refused while list enabled
	assign cand_ok = !amt_en || amt_hit;

	// rank key, lower is better: p1, gm flag, class, accuracy, variance, p2, id
	function automatic logic [64:0] rank(input gm_align_pkg::cand_t c);
		rank = {c.prio1, c.clk_class > `CLASS_GM_MAX, c.clk_class, c.accuracy,
			c.variance, c.prio2, c.id};
	endfunction : rank

	always_ff @(posedge clk) begin
		if (srst || cand_clear) begin
			best_valid_r <= 1'b0;
			best_r <= '0;
			best_gm_capable_r <= 1'b0;
		end else if (cand_valid && cand_ok &&
				(!best_valid_r || rank(eff) < rank(best_r))) begin
			best_valid_r <= 1'b1;
			best_r <= eff;
			// class above limit flagged not grandmaster
			best_gm_capable_r <= eff.clk_class <= `CLASS_GM_MAX;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cand_reject_r <= 1'b0;
		end else begin
			cand_reject_r <= cand_valid && !cand_ok;
		end
	end

	// pulse comes only from host-selected input
	assign pps_now = gm_mode && reference_clock_input[ref_sel];
	assign pps_edge = pps_now && !pps_d_r;

	// activity window restarted by each edge
	always_ff @(posedge clk) begin
		if (srst) begin
			pps_d_r <= 1'b0;
			pps_cnt_r <= 32'h0000_0000;
			pps_lost_r <= 1'b1;
		end else begin
			pps_d_r <= pps_now;
			if (pps_edge) begin
				pps_cnt_r <= 32'h0000_0000;
				pps_lost_r <= 1'b0;
			end else if (pps_cnt_r >= PPS_WIN - 32'h0000_0001) begin
				pps_lost_r <= 1'b1;
			end else begin
				pps_cnt_r <= pps_cnt_r + 32'h0000_0001;
			end
		end
	end

	// holdover only after long enough lock
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= gm_align_pkg::ST_FREE;
			lock_secs_r <= 8'h00;
		end else begin
			case (state_r)
				gm_align_pkg::ST_FREE, gm_align_pkg::ST_HOLD: begin
					lock_secs_r <= 8'h00;
					if (pps_edge) begin
						state_r <= gm_align_pkg::ST_LOCKING;
					end
				end
				gm_align_pkg::ST_LOCKING: begin
					if (pps_lost_r) begin
						state_r <= gm_align_pkg::ST_FREE;
					end else if (lock_secs_r >= `HOLD_MIN_SECS) begin
						state_r <= gm_align_pkg::ST_LOCKED;
					end else if (pps_edge) begin
						lock_secs_r <= lock_secs_r + 8'h01;
					end
				end
				gm_align_pkg::ST_LOCKED: begin
					if (pps_lost_r) begin
						state_r <= gm_align_pkg::ST_HOLD;
					end
				end
				default: begin
					state_r <= gm_align_pkg::ST_FREE;
				end
			endcase
		end
	end

	// sentence parser; digits accumulate into two-digit fields
	assign is_dig = ser_byte >= `CH_0 && ser_byte <= `CH_9;
	assign dig = ser_byte - `CH_0;
	assign msg_end = ser_valid && (ser_byte == `CH_STAR || ser_byte == `CH_LF);
	// only time sentences with both fields count
	assign msg_good = msg_end && zda_r && fld_r >= 4'h2;

	always_ff @(posedge clk) begin
		if (srst) begin
			idx_r <= 8'hff;
			fld_r <= 4'h0;
			pos_r <= 4'h0;
			zda_r <= 1'b0;
			hh_r <= 8'h00;
			mm_r <= 8'h00;
			ss_r <= 8'h00;
			dd_r <= 8'h00;
		end else if (ser_valid) begin
			if (ser_byte == `CH_DOLLAR) begin
				idx_r <= 8'h00;
				fld_r <= 4'h0;
				pos_r <= 4'h0;
				zda_r <= 1'b1;
			end else if (msg_end) begin
				zda_r <= 1'b0;
			end else if (idx_r != 8'hff) begin
				idx_r <= idx_r + 8'h01;
				// talker is two letters, type three letters at 2..4
				if ((idx_r == 8'h02 && ser_byte != `CH_Z) ||
						(idx_r == 8'h03 && ser_byte != `CH_D) ||
						(idx_r == 8'h04 && ser_byte != `CH_A)) begin
					zda_r <= 1'b0;
				end
				if (ser_byte == `CH_COMMA) begin
					fld_r <= fld_r + 4'h1;
					pos_r <= 4'h0;
				end else if (is_dig) begin
					pos_r <= pos_r + 4'h1;
					if (fld_r == 4'h1 && pos_r < 4'h2) begin
						hh_r <= 8'(hh_r * 8'd10 + dig);
					end else if (fld_r == 4'h1 && pos_r < 4'h4) begin
						mm_r <= 8'(mm_r * 8'd10 + dig);
					end else if (fld_r == 4'h1 && pos_r < 4'h6) begin
						ss_r <= 8'(ss_r * 8'd10 + dig);
					end else if (fld_r == 4'h2 && pos_r < 4'h2) begin
						dd_r <= 8'(dd_r * 8'd10 + dig);
					end
				end
			end
			if (ser_byte == `CH_DOLLAR) begin
				hh_r <= 8'h00;
				mm_r <= 8'h00;
				ss_r <= 8'h00;
				dd_r <= 8'h00;
			end
		end
	end

	// silence or framing error marks serial input failed
	always_ff @(posedge clk) begin
		if (srst) begin
			ser_fail_r <= 1'b1;
			ser_cnt_r <= 32'h0000_0000;
		end else if (ser_valid && ser_err) begin
			ser_fail_r <= 1'b1;
		end else if (msg_good) begin
			ser_fail_r <= 1'b0;
			ser_cnt_r <= 32'h0000_0000;
		end else if (ser_cnt_r >= SER_WIN - 32'h0000_0001) begin
			ser_fail_r <= 1'b1;
		end else begin
			ser_cnt_r <= ser_cnt_r + 32'h0000_0001;
		end
	end

	// message names the second beginning at the next edge
	// message relies on arriving ahead of its pulse
	always_ff @(posedge clk) begin
		if (srst) begin
			pend_v_r <= 1'b0;
			pend_sec_r <= 17'h0_0000;
			pend_day_r <= 8'h00;
		end else if (msg_good && !ser_fail_r) begin
			pend_v_r <= 1'b1;
			pend_sec_r <= 17'(hh_r * 17'd3600 + mm_r * 17'd60 + ss_r);
			pend_day_r <= dd_r;
		end else if (pps_edge || ser_fail_r) begin
			pend_v_r <= 1'b0;
		end
	end

	// pulse edge forces the seconds rollover onto itself
	// second count follows the source epoch
	always_ff @(posedge clk) begin
		if (srst) begin
			sub_r <= 24'h00_0000;
			sec_r <= 17'h0_0000;
			day_r <= 8'h00;
			top_sec_r <= 1'b0;
		end else begin
			top_sec_r <= 1'b0;
			if (pps_edge) begin
				sub_r <= 24'h00_0000;
				top_sec_r <= 1'b1;
				if (pend_v_r) begin
					sec_r <= pend_sec_r;
					day_r <= pend_day_r;
				end else if (sub_r >= `SEC_HALF) begin
					sec_r <= (sec_r >= `DAY_LAST_SEC) ? 17'h0_0000 : sec_r + 17'h0_0001;
				end
			end else if (sub_r >= `SEC_LAST) begin
				// free-running or holdover rollover
				sub_r <= 24'h00_0000;
				top_sec_r <= 1'b1;
				sec_r <= (sec_r >= `DAY_LAST_SEC) ? 17'h0_0000 : sec_r + 17'h0_0001;
				if (sec_r >= `DAY_LAST_SEC) begin
					day_r <= day_r + 8'h01;
				end
			end else begin
				sub_r <= sub_r + 24'h00_0001;
			end
		end
	end

	// quality taken only from host settings
	always_ff @(posedge clk) begin
		if (srst) begin
			ann_r <= '0;
		end else begin
			ann_r.ptp_timescale <= cfg.traceable;
			ann_r.time_traceable <= cfg.traceable;
			ann_r.freq_traceable <= 1'b1;
			ann_r.leap61 <= cfg.traceable && cfg.leap61;
			ann_r.leap59 <= cfg.traceable && cfg.leap59;
			ann_r.utc_offset_valid <= cfg.traceable;
			ann_r.utc_offset <= cfg.utc_offset;
			ann_r.time_source <= cfg.time_source;
			ann_r.accuracy <= cfg.accuracy;
			ann_r.variance <= cfg.variance;
			if (cfg.profile_active) begin
				ann_r.clk_class <= cfg.clk_class;
			end else begin
				ann_r.clk_class <= cfg.traceable ? `CLASS_TRACE_DFLT : `CLASS_ARB_DFLT;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_amt_reject: assert property (cand_valid && amt_en && !amt_hit && !cand_clear |=>
		best_r == $past(best_r) && cand_reject_r) else $error("unlisted master taken");
	a_amt_prio: assert property (cand_valid && amt_en && amt_hit && !best_valid_r
		&& !cand_clear |=> best_r.prio1 == $past(eff_p1)) else $error("list prio unused");
	a_better_p1: assert property (cand_valid && !amt_en && best_valid_r && !cand_clear
		&& cand.prio1 < best_r.prio1 |=> best_r == $past(cand)) else $error("p1 ignored");
	a_pps_steer: assert property (pps_edge |=> sub_r == 24'h00_0000 && top_sec_r)
		else $error("rollover not on edge");
	a_pps_loss: assert property (pps_cnt_r == PPS_WIN - 32'h0000_0001 && !pps_edge
		|=> pps_lost_r) else $error("loss missed");
	a_hold_entry: assert property (state_r == gm_align_pkg::ST_LOCKED && pps_lost_r
		|=> state_r == gm_align_pkg::ST_HOLD) else $error("no holdover");
	a_ser_fail: assert property (ser_valid && ser_err |=> ser_fail_r ##1 !pend_v_r)
		else $error("serial failure missed");
	a_trace_ann: assert property (cfg.traceable && !cfg.profile_active |=>
		ann_r.clk_class == `CLASS_TRACE_DFLT && ann_r.time_traceable) else $error("class");
	a_arb_ann: assert property (!cfg.traceable && !cfg.profile_active |=>
		ann_r.clk_class == `CLASS_ARB_DFLT && !ann_r.ptp_timescale && ann_r.freq_traceable)
		else $error("non-traceable announce wrong");

	c_lock_hold: cover property (state_r == gm_align_pkg::ST_LOCKED ##1
		state_r == gm_align_pkg::ST_HOLD);
	c_tod_applied: cover property (pend_v_r && pps_edge);
	c_amt_reject: cover property (cand_reject_r);
	c_best_swap: cover property (best_valid_r ##1 cand_valid ##1 $changed(best_r));
endmodule : gm_align

// ---- logic/gm_align_cfg.svh ----
// constants for master selection and timebase alignment
`ifndef GM_ALIGN_CFG_SVH
`define GM_ALIGN_CFG_SVH
`define CLK_HZ 10000000
`define SEC_LAST 24'h98_967f
`define SEC_HALF 24'h4c_4b40
`define PPS_WIN_MS 1200
`define SER_WIN_MS 2500
`define PPS_WIN_CYC (64'd`PPS_WIN_MS * 64'd`CLK_HZ / 64'd1000)
`define SER_WIN_CYC (64'd`SER_WIN_MS * 64'd`CLK_HZ / 64'd1000)
`define DAY_LAST_SEC 17'h1_517f
`define HOLD_MIN_SECS 8'h10
`define CLASS_GM_MAX 8'h7f
`define CLASS_TRACE_DFLT 8'h06
`define CLASS_ARB_DFLT 8'h0d
`define AMT_DEPTH 8
`define CH_DOLLAR 8'h24
`define CH_COMMA 8'h2c
`define CH_STAR 8'h2a
`define CH_LF 8'h0a
`define CH_Z 8'h5a
`define CH_D 8'h44
`define CH_A 8'h41
`define CH_0 8'h30
`define CH_9 8'h39
`endif

// ---- logic/gm_align_pkg.sv ----
// types for master selection and timebase alignment
package gm_align_pkg;
	typedef struct packed {
		logic [15:0] id;
		logic [7:0] prio1;
		logic [7:0] clk_class;
		logic [7:0] accuracy;
		logic [15:0] variance;
		logic [7:0] prio2;
	} cand_t;
	typedef struct packed {
		logic traceable;
		logic profile_active;
		logic [7:0] clk_class;
		logic [7:0] accuracy;
		logic [15:0] variance;
		logic [15:0] utc_offset;
		logic [7:0] time_source;
		logic leap61;
		logic leap59;
	} cfg_t;
	typedef struct packed {
		logic ptp_timescale;
		logic time_traceable;
		logic freq_traceable;
		logic leap61;
		logic leap59;
		logic utc_offset_valid;
		logic [15:0] utc_offset;
		logic [7:0] time_source;
		logic [7:0] clk_class;
		logic [7:0] accuracy;
		logic [15:0] variance;
	} ann_t;
	typedef enum logic [3:0] {
		ST_FREE = 4'b0001,
		ST_LOCKING = 4'b0010,
		ST_LOCKED = 4'b0100,
		ST_HOLD = 4'b1000
	} sync_state_t;
endpackage : gm_align_pkg
